// *** pkg/sdtc_pkg.sv ***
// sdtc_pkg: constants and types shared by the scan delay timer/counter block.
// assumes a 125 MHz system clock and a data register area starting at 4096.
package sdtc_pkg;

  //////////////////////////////////////////////////////////////////////////////
  // clock and time bases
  localparam int unsigned CLK_HZ           = 125_000_000;
  localparam int unsigned TICK_PERIOD_US   = 10_000;
  localparam int unsigned TICK_CYCLES_DFLT = (CLK_HZ / 1_000_000) * TICK_PERIOD_US;
  localparam int unsigned TICK_CNT_W       = 21;
  localparam logic [3:0]  HUNDREDTHS_PER_TENTH = 4'h9;
  localparam logic [3:0]  TENTHS_PER_SECOND    = 4'h9;
  localparam int unsigned NUM_BASES        = 3;
  localparam int unsigned ELAPSED_W        = 8;
  localparam logic [7:0]  ELAPSED_MAX      = 8'hFF;

  //////////////////////////////////////////////////////////////////////////////
  // element capacity and address map
  localparam int unsigned VAL_W           = 16;
  localparam int unsigned DADDR_W         = 13;
  localparam int unsigned IOADDR_W        = 10;
  localparam int unsigned OFFS_W          = 14;
  localparam logic [12:0] DATA_BASE       = 13'h1000;
  localparam logic [13:0] ACC_STEP        = 14'h0001;
  localparam int unsigned MAX_ELEM_SMALL  = 128;
  localparam int unsigned MAX_ELEM_LARGE  = 2048;
  localparam int unsigned REGS_PER_ELEM   = 2;
  localparam int unsigned IO_BITS_SMALL   = 256;
  localparam int unsigned IO_BITS_LARGE   = 1024;
  localparam logic [15:0] VAL_ZERO        = 16'h0000;
  localparam logic [15:0] VAL_ONE         = 16'h0001;

  //////////////////////////////////////////////////////////////////////////////
  // instruction kinds and time bases
  typedef enum logic [2:0]
  {
    OP_ON_DELAY,
    OP_OFF_DELAY,
    OP_COUNT_UP,
    OP_COUNT_DOWN,
    OP_COUNT_CLEAR
  } sdtc_op_t;

  typedef enum logic [1:0]
  {
    BASE_SECOND,
    BASE_TENTH,
    BASE_HUNDREDTH
  } sdtc_base_t;

endpackage

// *** rtl/sdtc_elem.sv ***
// sdtc_elem: next accumulator, coil and output of one element execution.
// assumes preset and accumulator are already read from the register pair.
`timescale 1ns/1ps
module sdtc_elem (
  // instruction
  input  sdtc_pkg::sdtc_op_t          op_i,
  input  wire logic                   rung_i,
  input  wire logic                   signed_i,
  input  wire logic                   restart_i,
  input  wire logic [7:0]             elapsed_i,
  // element state
  input  wire logic [15:0]            preset_i,
  input  wire logic [15:0]            acc_i,
  input  wire logic                   coil_i,
  // results
  output logic [15:0]                 acc_o,
  output logic                        coil_o,
  output logic                        reached_o
);

  logic [16:0] sum;
  logic [15:0] timed;

  // accumulator advance saturating at the preset
  assign sum   = {1'b0, acc_i} + {9'h000, elapsed_i};
  assign timed = (acc_i >= preset_i || sum >= {1'b0, preset_i}) ?
                 ((acc_i >= preset_i) ? acc_i : preset_i) : sum[15:0]; // RULE_22

  always_comb
  begin
    acc_o  = acc_i;
    coil_o = coil_i;
    unique case (op_i)
      sdtc_pkg::OP_ON_DELAY:
      begin
        if (!rung_i || restart_i)
        begin
          acc_o  = sdtc_pkg::VAL_ZERO; // RULE_20
          coil_o = 1'b0;                // RULE_17
        end
        else
        begin
          acc_o  = timed;                   // RULE_18
          // an energized coil is kept even if the preset is raised meanwhile
          coil_o = coil_i || (timed >= preset_i);   // RULE_18 RULE_19
        end
      end
      sdtc_pkg::OP_OFF_DELAY:
      begin
        if (restart_i)
        begin
          acc_o  = sdtc_pkg::VAL_ZERO;
          coil_o = 1'b0;
        end
        else if (rung_i)
        begin
          acc_o  = sdtc_pkg::VAL_ZERO;
          coil_o = 1'b1;
        end
        else
        begin
          acc_o  = timed;
          coil_o = coil_i && (timed < preset_i);
        end
      end
      // counters wrap through all 65536 values
      sdtc_pkg::OP_COUNT_UP:
        acc_o = rung_i ? acc_i + sdtc_pkg::VAL_ONE : acc_i;   // RULE_12
      sdtc_pkg::OP_COUNT_DOWN:
        acc_o = rung_i ? acc_i - sdtc_pkg::VAL_ONE : acc_i;   // RULE_12
      sdtc_pkg::OP_COUNT_CLEAR:
        acc_o = rung_i ? sdtc_pkg::VAL_ZERO : acc_i;
      default:
        acc_o = acc_i;
    endcase
  end

  // counters report reached in the chosen number mode
  always_comb
  begin
    if (op_i == sdtc_pkg::OP_ON_DELAY || op_i == sdtc_pkg::OP_OFF_DELAY)
      reached_o = coil_o;
    else if (signed_i)
      reached_o = ($signed(acc_o) >= $signed(preset_i));      // RULE_12
    else
      reached_o = (acc_o >= preset_i);                        // RULE_11
  end

endmodule

// *** rtl/sdtc_tick.sv ***
// sdtc_tick: hundredth-second tick with tenth and second divisions, and the
// count of each base's ticks seen during the previous scan.
// assumes scan_start_i pulses once at the start of every program scan.
`timescale 1ns/1ps
module sdtc_tick #(
  parameter int unsigned TICK_CYCLES = sdtc_pkg::TICK_CYCLES_DFLT
)(
  // clock and reset
  input  wire logic                   clk_sys_i,
  input  wire logic                   arst_n_i,
  // scan boundary
  input  wire logic                   scan_start_i,
  // per-base elapsed ticks of the last full scan: 0 second, 1 tenth, 2 hundredth
  output logic [2:0][7:0]             elapsed_o,
  output logic                        tick_h_o
);

  localparam logic [20:0] TICK_LAST = 21'(TICK_CYCLES - 1);

  logic [20:0]      cnt_q;
  logic [3:0]       div_t_q;
  logic [3:0]       div_s_q;
  logic [2:0]       tick;
  logic [2:0][7:0]  run_q;

  //////////////////////////////////////////////////////////////////////////////
  // periodic hundredth-second interrupt and its decimal divisions
  always_ff @(posedge clk_sys_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
      cnt_q <= '0;
    else if (cnt_q == TICK_LAST)
      cnt_q <= '0;
    else
      cnt_q <= cnt_q + 21'h0_0001;
  end

  assign tick[2] = (cnt_q == TICK_LAST);
  assign tick[1] = tick[2] && (div_t_q == sdtc_pkg::HUNDREDTHS_PER_TENTH);
  assign tick[0] = tick[1] && (div_s_q == sdtc_pkg::TENTHS_PER_SECOND);
  assign tick_h_o = tick[2];

  always_ff @(posedge clk_sys_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      div_t_q <= '0;
      div_s_q <= '0;
    end
    else
    begin
      if (tick[2])
        div_t_q <= tick[1] ? 4'h0 : div_t_q + 4'h1;
      if (tick[1])
        div_s_q <= tick[0] ? 4'h0 : div_s_q + 4'h1;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // ticks are gathered per scan; a scan longer than 255 ticks saturates
  for (genvar b = 0; b < sdtc_pkg::NUM_BASES; b++)
  begin : g_base
    always_ff @(posedge clk_sys_i or negedge arst_n_i)
    begin
      if (!arst_n_i)
      begin
        run_q[b]     <= '0;
        elapsed_o[b] <= '0;
      end
      else if (scan_start_i)
      begin
        run_q[b]     <= {7'h00, tick[b]};
        elapsed_o[b] <= run_q[b];
      end
      else if (tick[b] && run_q[b] != sdtc_pkg::ELAPSED_MAX)
        run_q[b] <= run_q[b] + 8'h01;
    end
  end

  property p_tick_period;
    @(posedge clk_sys_i) disable iff (!arst_n_i)
    tick_h_o |=> (cnt_q == 21'h0_0000) && !tick_h_o;
  endproperty
  a_tick_period: assert property (p_tick_period) // RULE_09
    else $error("hundredth tick not periodic");

endmodule

// *** rtl/sdtc_timer_counter.sv ***
// sdtc_timer_counter: scan-driven timer and counter element engine with the
// register data table and the coil part of the i/o status table.
// assumes the rung solver presents one element per exec_i pulse, in scan order.
//
// Summary of operation
// RULE_01: each element keeps preset and accumulator in any consecutive data register pair.
// RULE_02: the preset register sits one address below the accumulator register.
// RULE_03: programmer should put accumulators at odd addresses for densest packing.
// RULE_04: on and off delay timers also name one i/o bit as their coil.
// RULE_05: coil states live in the i/o status table, values in the data table.
// RULE_06: the small variant holds at most 128 elements in any mix.
// RULE_07: the large variant holds at most 2048 elements in any mix.
// RULE_08: hundredth-second timers must lie in registers 4097 to 4111 where required; the code accepts any base at any pair in the data area.
// RULE_09: hundredth-second timers advance from a 0.01 s tick; error one scan.
// RULE_10: programmer may repeat a hundredth timer to cut its error.
// RULE_11: timers count upward from zero to an unsigned 16-bit preset.
// RULE_12: counters count up or down through 65536 values, unsigned or signed.
// RULE_13: preset and accumulator stay ordinary registers, readable and writable anytime.
// RULE_14: every timer and counter output can be forced to a fixed state.
// RULE_15: only the preset address identifies an element; accumulator is derived.
// RULE_16: programmer allows at most one retentive element per logic line.
// RULE_17: on delay coil is off while its rung condition is false.
// RULE_18: with rung true the on delay accumulates and energizes at the preset.
// RULE_19: the energized coil drops at once when the rung goes false.
// RULE_20: on delay accumulator clears on a false rung and after power returns.
// RULE_21: each timer uses a one, tenth or hundredth second time base.
// RULE_22: a reached on delay accumulator holds at the preset while rung stays true.
`timescale 1ns/1ps
module sdtc_timer_counter #(
  parameter bit          LARGE_VARIANT = 1'b1,
  parameter int unsigned TICK_CYCLES   = sdtc_pkg::TICK_CYCLES_DFLT
)(
  // clock and reset
  input  wire logic                   clk_sys_i,
  input  wire logic                   arst_n_i,
  // scan control
  input  wire logic                   scan_start_i,
  input  wire logic                   pwr_restore_i,
  // element execution
  input  wire logic                   exec_i,
  input  sdtc_pkg::sdtc_op_t          op_i,
  input  sdtc_pkg::sdtc_base_t        base_i,
  input  wire logic                   rung_i,
  input  wire logic                   signed_i,
  input  wire logic [12:0]            preset_addr_i,
  input  wire logic [9:0]             coil_addr_i,
  input  wire logic                   force_en_i,
  input  wire logic                   force_val_i,
  output logic                        done_o,
  output logic                        err_o,
  output logic                        out_o,
  // data manipulation access to the register data table
  input  wire logic                   dm_we_i,
  input  wire logic [12:0]            dm_addr_i,
  input  wire logic [15:0]            dm_wdata_i,
  output logic [15:0]                 dm_rdata_o,
  // i/o status table read
  input  wire logic [9:0]             io_addr_i,
  output logic                        io_rdata_o
);

  localparam int unsigned MAX_ELEM = LARGE_VARIANT ? sdtc_pkg::MAX_ELEM_LARGE
                                                   : sdtc_pkg::MAX_ELEM_SMALL;
  localparam int unsigned NREGS    = sdtc_pkg::REGS_PER_ELEM * MAX_ELEM;
  localparam int unsigned NIO      = LARGE_VARIANT ? sdtc_pkg::IO_BITS_LARGE
                                                   : sdtc_pkg::IO_BITS_SMALL;
  localparam logic [13:0] NREGS_W  = 14'(NREGS);
  localparam logic [9:0]  NIO_LAST = 10'(NIO - 1);

  //////////////////////////////////////////////////////////////////////////////
  // storage: register data table and coil bits of the i/o status table
  logic [15:0]      regs_q [NREGS];
  logic [NIO-1:0]   io_q;

  logic [13:0]      pre_offs;
  logic [13:0]      acc_offs;
  logic [11:0]      pidx;
  logic [11:0]      aidx;
  logic [13:0]      dm_offs;
  logic [11:0]      dm_idx;
  logic             dm_ok;
  logic             is_timer;
  logic             in_range;
  logic             exec_ok;
  logic [15:0]      pre_rd;
  logic [15:0]      acc_rd;
  logic             coil_rd;
  logic [7:0]       elapsed;
  logic [2:0][7:0]  elapsed_all;
  logic [15:0]      acc_nxt;
  logic             coil_nxt;
  logic             reached;
  logic             out_d;
  logic             restart_pend_q;
  logic             restart_q;

  //////////////////////////////////////////////////////////////////////////////
  // element addressing
  // the program stores only the preset address; the accumulator follows it
  assign pre_offs = {1'b0, preset_addr_i} - {1'b0, sdtc_pkg::DATA_BASE};   // RULE_15
  assign acc_offs = pre_offs + sdtc_pkg::ACC_STEP;                         // RULE_02
  assign pidx     = pre_offs[11:0];
  assign aidx     = acc_offs[11:0];
  assign is_timer = (op_i == sdtc_pkg::OP_ON_DELAY) || (op_i == sdtc_pkg::OP_OFF_DELAY);

  // any pair inside the data area is legal; the area size sets the capacity
  assign in_range = !pre_offs[13] && (acc_offs < NREGS_W)                 // RULE_01 RULE_06 RULE_07
                    && (!is_timer || coil_addr_i <= NIO_LAST);             // RULE_04
  assign exec_ok  = exec_i && in_range;

  assign pre_rd   = in_range ? regs_q[pidx] : sdtc_pkg::VAL_ZERO;
  assign acc_rd   = in_range ? regs_q[aidx] : sdtc_pkg::VAL_ZERO;
  assign coil_rd  = (coil_addr_i <= NIO_LAST) ? io_q[coil_addr_i] : 1'b0;

  assign dm_offs  = {1'b0, dm_addr_i} - {1'b0, sdtc_pkg::DATA_BASE};
  assign dm_idx   = dm_offs[11:0];
  assign dm_ok    = !dm_offs[13] && (dm_offs < NREGS_W);

  //////////////////////////////////////////////////////////////////////////////
  // time bases
  sdtc_tick #(
    .TICK_CYCLES (TICK_CYCLES)
  ) u_tick (
    .clk_sys_i    (clk_sys_i),
    .arst_n_i     (arst_n_i),
    .scan_start_i (scan_start_i),
    .elapsed_o    (elapsed_all),
    .tick_h_o     ()
  );

  // the base is picked by base_i, beside op_i; ticks of the last scan are applied, so
  // a hundredth timer lags the interrupt by at most one scan
  always_comb
  begin
    unique case (base_i)
      sdtc_pkg::BASE_SECOND:    elapsed = elapsed_all[0];   // RULE_21
      sdtc_pkg::BASE_TENTH:     elapsed = elapsed_all[1];   // RULE_21
      sdtc_pkg::BASE_HUNDREDTH: elapsed = elapsed_all[2];   // RULE_09
      default:                  elapsed = '0;
    endcase
  end

  //////////////////////////////////////////////////////////////////////////////
  // power return: the whole next scan runs as a restart scan
  always_ff @(posedge clk_sys_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      restart_pend_q <= 1'b1;
      restart_q      <= 1'b0;
    end
    else
    begin
      if (scan_start_i)
        restart_q <= restart_pend_q;
      // a restore in the same cycle as the scan start is kept for the next scan
      if (pwr_restore_i)
        restart_pend_q <= 1'b1;
      else if (scan_start_i)
        restart_pend_q <= 1'b0;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // element behaviour
  sdtc_elem u_elem (
    .op_i      (op_i),
    .rung_i    (rung_i),
    .signed_i  (signed_i),
    .restart_i (restart_q),
    .elapsed_i (elapsed),
    .preset_i  (pre_rd),
    .acc_i     (acc_rd),
    .coil_i    (coil_rd),
    .acc_o     (acc_nxt),
    .coil_o    (coil_nxt),
    .reached_o (reached)
  );

  assign out_d = force_en_i ? force_val_i : reached;   // RULE_14

  //////////////////////////////////////////////////////////////////////////////
  // register data table; the element write lands last, so it wins a same-cycle
  // clash with a data manipulation write to the accumulator
  always_ff @(posedge clk_sys_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      for (int i = 0; i < NREGS; i++)
        regs_q[i] <= sdtc_pkg::VAL_ZERO;
    end
    else
    begin
      if (dm_we_i && dm_ok)
        regs_q[dm_idx] <= dm_wdata_i;    // RULE_13
      if (exec_ok)
        regs_q[aidx] <= acc_nxt;         // RULE_05
    end
  end

  // coil bits of on and off delay timers, forced state included
  always_ff @(posedge clk_sys_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
      io_q <= '0;
    else if (exec_ok && is_timer)
      io_q[coil_addr_i] <= force_en_i ? force_val_i : coil_nxt;   // RULE_04 RULE_05 RULE_14
  end

  //////////////////////////////////////////////////////////////////////////////
  // answers
  always_ff @(posedge clk_sys_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      done_o <= 1'b0;
      err_o  <= 1'b0;
      out_o  <= 1'b0;
    end
    else
    begin
      done_o <= exec_ok;
      err_o  <= exec_i && !in_range;
      if (exec_ok)
        out_o <= out_d;
    end
  end

  // read ports see the table as it stood before this edge
  always_ff @(posedge clk_sys_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      dm_rdata_o <= '0;
      io_rdata_o <= 1'b0;
    end
    else
    begin
      dm_rdata_o <= dm_ok ? regs_q[dm_idx] : sdtc_pkg::VAL_ZERO;   // RULE_13
      io_rdata_o <= (io_addr_i <= NIO_LAST) ? io_q[io_addr_i] : 1'b0;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge clk_sys_i);
  endclocking
  default disable iff (!arst_n_i);

  logic dm_hits_acc;
  assign dm_hits_acc = dm_we_i && dm_ok && (dm_idx == aidx);

  property p_pair;
    exec_ok && !dm_hits_acc |=> regs_q[$past(aidx)] == $past(acc_nxt)
                               && $past(aidx) == $past(pidx) + 12'h001;
  endproperty
  a_pair: assert property (p_pair) // RULE_02
    else $error("accumulator not stored above preset");

  property p_range;
    exec_i && !in_range |=> err_o && !done_o;
  endproperty
  a_range: assert property (p_range) // RULE_06
    else $error("out of range element was executed");

  property p_off_rung;
    exec_ok && op_i == sdtc_pkg::OP_ON_DELAY && !rung_i && !force_en_i
      |=> !out_o && !io_q[$past(coil_addr_i)] ##1 !out_o || done_o;
  endproperty
  a_off_rung: assert property (p_off_rung) // RULE_17
    else $error("on delay coil on with false rung");

  property p_clear;
    exec_ok && op_i == sdtc_pkg::OP_ON_DELAY && (!rung_i || restart_q) && !dm_hits_acc
      |=> regs_q[$past(aidx)] == sdtc_pkg::VAL_ZERO;
  endproperty
  a_clear: assert property (p_clear) // RULE_20
    else $error("on delay accumulator not cleared");

  property p_energize;
    exec_ok && op_i == sdtc_pkg::OP_ON_DELAY && rung_i && !restart_q && !force_en_i
      && ({1'b0, acc_rd} + {9'h000, elapsed} >= {1'b0, pre_rd})
      |=> out_o && io_q[$past(coil_addr_i)];
  endproperty
  a_energize: assert property (p_energize) // RULE_18
    else $error("on delay coil not energized at preset");

  property p_hold;
    exec_ok && op_i == sdtc_pkg::OP_ON_DELAY && rung_i && !restart_q
      && acc_rd >= pre_rd && !dm_hits_acc
      |=> regs_q[$past(aidx)] == $past(acc_rd);
  endproperty
  a_hold: assert property (p_hold) // RULE_22
    else $error("reached accumulator moved");

  property p_force;
    exec_ok && force_en_i |=> done_o && out_o == $past(force_val_i);
  endproperty
  a_force: assert property (p_force) // RULE_14
    else $error("forced output not applied");

  property p_count;
    exec_ok && op_i == sdtc_pkg::OP_COUNT_UP && rung_i && !dm_hits_acc
      |=> regs_q[$past(aidx)] == $past(acc_rd) + sdtc_pkg::VAL_ONE;
  endproperty
  a_count: assert property (p_count) // RULE_12
    else $error("up counter did not advance by one");

  property p_dm_write;
    dm_we_i && dm_ok && !(exec_ok && dm_idx == aidx)
      |=> regs_q[$past(dm_idx)] == $past(dm_wdata_i);
  endproperty
  a_dm_write: assert property (p_dm_write) // RULE_13
    else $error("data manipulation write lost");

  property p_restart;
    exec_ok && op_i == sdtc_pkg::OP_ON_DELAY && restart_q && !force_en_i
      |=> !out_o && !io_q[$past(coil_addr_i)];
  endproperty
  a_restart: assert property (p_restart) // RULE_20
    else $error("on delay coil kept over power return");

  property p_stay_on;
    exec_ok && op_i == sdtc_pkg::OP_ON_DELAY && rung_i && !restart_q && !force_en_i && coil_rd
      |=> out_o && io_q[$past(coil_addr_i)];
  endproperty
  a_stay_on: assert property (p_stay_on) // RULE_19
    else $error("energized on delay coil dropped with true rung");

  property p_accumulate;
    exec_ok && op_i == sdtc_pkg::OP_ON_DELAY && rung_i && !restart_q && !dm_hits_acc
      && ({1'b0, acc_rd} + {9'h000, elapsed} < {1'b0, pre_rd})
      |=> regs_q[$past(aidx)] == $past(acc_rd) + 16'($past(elapsed));
  endproperty
  a_accumulate: assert property (p_accumulate) // RULE_18
    else $error("on delay accumulator did not advance by elapsed ticks");

  property p_preset_kept;
    exec_ok && !(dm_we_i && dm_ok && dm_idx == pidx)
      |=> regs_q[$past(pidx)] == $past(pre_rd);
  endproperty
  a_preset_kept: assert property (p_preset_kept) // RULE_01
    else $error("element execution disturbed its preset register");

endmodule

// *** verification/sdtc_scan_model.sv ***
// sdtc_scan_model: rung solver stand-in that marks the start of each scan.
// assumes the bench executes its elements between two scan starts.
`timescale 1ns/1ps
module sdtc_scan_model #(
  parameter int unsigned SCAN_CYCLES = 60
)(
  // clock and reset
  input  wire logic clk_sys_i,
  input  wire logic arst_n_i,
  // scan boundary
  output logic      scan_start_o
);
  int unsigned cnt_q;

  // fixed scan length keeps the elapsed ticks per scan predictable
  always @(posedge clk_sys_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      cnt_q        <= 0;
      scan_start_o <= 1'b0;
    end
    else
    begin
      cnt_q        <= (cnt_q == SCAN_CYCLES - 1) ? 0 : cnt_q + 1;
      scan_start_o <= #1 (cnt_q == SCAN_CYCLES - 1);
    end
  end
endmodule

// *** verification/tb_sdtc_timer_counter.sv ***
// tb_sdtc_timer_counter: directed bench for the timer and counter engine.
// assumes 20-cycle hundredth ticks and 60-cycle scans from the scan model.
`timescale 1ns/1ps
module tb_sdtc_timer_counter;
  localparam logic [12:0] PAIR_A = 13'h1000;
  localparam logic [12:0] PAIR_B = 13'h1004;
  logic                 clk_sys_i, arst_n_i, scan_start, pwr, exec, rung, sgn, fen, fval;
  logic                 done, err, out, dm_we, io_rd;
  sdtc_pkg::sdtc_op_t   op;
  sdtc_pkg::sdtc_base_t base;
  logic [12:0]          paddr, dm_addr;
  logic [15:0]          dm_wdata, dm_rdata, v;
  int                   err_count, samples_checked;

  sdtc_scan_model #(.SCAN_CYCLES(60)) sdtc_scan_model_inst (.clk_sys_i(clk_sys_i),
    .arst_n_i(arst_n_i), .scan_start_o(scan_start));
  sdtc_timer_counter #(.LARGE_VARIANT(1'b1), .TICK_CYCLES(20)) sdtc_timer_counter_inst (
    .clk_sys_i(clk_sys_i), .arst_n_i(arst_n_i), .scan_start_i(scan_start),
    .pwr_restore_i(pwr), .exec_i(exec), .op_i(op), .base_i(base), .rung_i(rung),
    .signed_i(sgn), .preset_addr_i(paddr), .coil_addr_i(paddr[9:0]), .force_en_i(fen),
    .force_val_i(fval), .done_o(done), .err_o(err), .out_o(out), .dm_we_i(dm_we),
    .dm_addr_i(dm_addr), .dm_wdata_i(dm_wdata), .dm_rdata_o(dm_rdata),
    .io_addr_i(paddr[9:0]), .io_rdata_o(io_rd));

  //////////////////////////////////////////////////////////////////////////////
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      err_count++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic report_and_stop;
    if (err_count == 0 && samples_checked > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  task automatic wait_scan;
    int n;
    n = 0;
    do
    begin
      @(posedge clk_sys_i);
      n++;
    end while (scan_start !== 1'b1 && n < 200);
    if (n >= 200)
    begin
      err_count++;
      report_and_stop;
    end
    #1;
  endtask

  task automatic run(input sdtc_pkg::sdtc_op_t o, input sdtc_pkg::sdtc_base_t b,
                     input logic r, s, fe, fv, input logic [12:0] pa);
    @(posedge clk_sys_i);
    #1;
    op = o;
    base = b;
    rung = r;
    sgn = s;
    fen = fe;
    fval = fv;
    paddr = pa;
    exec = 1'b1;
    @(posedge clk_sys_i);
    #1;
    exec = 1'b0;
  endtask

  task automatic dm_write(input logic [12:0] a, input logic [15:0] d);
    @(posedge clk_sys_i);
    #1;
    dm_we = 1'b1;
    dm_addr = a;
    dm_wdata = d;
    @(posedge clk_sys_i);
    #1;
    dm_we = 1'b0;
  endtask

  task automatic dm_read(input logic [12:0] a);
    @(posedge clk_sys_i);
    #1;
    dm_addr = a;
    @(posedge clk_sys_i);
    #1;
    v = dm_rdata;
  endtask

  //////////////////////////////////////////////////////////////////////////////
  // clear, hold the rung true for n scans, then drop it again
  task automatic on_delay(input sdtc_pkg::sdtc_base_t b, input logic [15:0] p,
                          input int n, input logic e);
    dm_write(PAIR_A, p);
    wait_scan;
    run(sdtc_pkg::OP_ON_DELAY, b, 1'b0, 1'b0, 1'b0, 1'b0, PAIR_A);
    check(out, 16'h0000);
    repeat (n)
    begin
      wait_scan;
      run(sdtc_pkg::OP_ON_DELAY, b, 1'b1, 1'b0, 1'b0, 1'b0, PAIR_A);
    end
    check(out, e);
    dm_read(PAIR_A + 13'h0001);
    if (e)
      check(v, p);
    check(io_rd, e);
    wait_scan;
    run(sdtc_pkg::OP_ON_DELAY, b, 1'b0, 1'b0, 1'b0, 1'b0, PAIR_A);
    check(out, 16'h0000);
    dm_read(PAIR_A + 13'h0001);
    check(v, 16'h0000);
  endtask

  task automatic power_return;
    repeat (3)
    begin
      wait_scan;
      run(sdtc_pkg::OP_ON_DELAY, sdtc_pkg::BASE_HUNDREDTH, 1'b1, 1'b0, 1'b0, 1'b0, PAIR_A);
    end
    check(out, 16'h0001);
    pwr = 1'b1;
    @(posedge clk_sys_i);
    #1;
    pwr = 1'b0;
    wait_scan;
    run(sdtc_pkg::OP_ON_DELAY, sdtc_pkg::BASE_HUNDREDTH, 1'b1, 1'b0, 1'b0, 1'b0, PAIR_A);
    check(out, 16'h0000);
  endtask

  task automatic counting;
    dm_write(PAIR_B, 16'h0002);
    run(sdtc_pkg::OP_COUNT_CLEAR, sdtc_pkg::BASE_SECOND, 1'b1, 1'b0, 1'b0, 1'b0, PAIR_B);
    run(sdtc_pkg::OP_COUNT_UP, sdtc_pkg::BASE_SECOND, 1'b1, 1'b0, 1'b0, 1'b0, PAIR_B);
    check(out, 16'h0000);
    run(sdtc_pkg::OP_COUNT_UP, sdtc_pkg::BASE_SECOND, 1'b0, 1'b0, 1'b0, 1'b0, PAIR_B);
    run(sdtc_pkg::OP_COUNT_UP, sdtc_pkg::BASE_SECOND, 1'b1, 1'b0, 1'b0, 1'b0, PAIR_B);
    check(out, 16'h0001);
    dm_read(PAIR_B + 13'h0001);
    check(v, 16'h0002);
    dm_write(PAIR_B + 13'h0001, 16'h7FFF);
    run(sdtc_pkg::OP_COUNT_UP, sdtc_pkg::BASE_SECOND, 1'b1, 1'b1, 1'b0, 1'b0, PAIR_B);
    check(out, 16'h0000);
    dm_read(PAIR_B + 13'h0001);
    check(v, 16'h8000);
    run(sdtc_pkg::OP_COUNT_CLEAR, sdtc_pkg::BASE_SECOND, 1'b1, 1'b0, 1'b0, 1'b0, PAIR_B);
    run(sdtc_pkg::OP_COUNT_DOWN, sdtc_pkg::BASE_SECOND, 1'b1, 1'b0, 1'b0, 1'b0, PAIR_B);
    check(out, 16'h0001);
    dm_read(PAIR_B + 13'h0001);
    check(v, 16'hFFFF);
  endtask

  task automatic force_and_refuse;
    // a scan past the restart scan, so the off delay coil is not cleared
    wait_scan;
    run(sdtc_pkg::OP_OFF_DELAY, sdtc_pkg::BASE_SECOND, 1'b1, 1'b0, 1'b0, 1'b0, PAIR_A);
    check(out, 16'h0001);
    run(sdtc_pkg::OP_ON_DELAY, sdtc_pkg::BASE_SECOND, 1'b0, 1'b0, 1'b1, 1'b1, PAIR_B);
    check(out, 16'h0001);
    run(sdtc_pkg::OP_ON_DELAY, sdtc_pkg::BASE_SECOND, 1'b1, 1'b0, 1'b0, 1'b0, 13'h0FFF);
    check({err, done}, 16'h0002);
    run(sdtc_pkg::OP_ON_DELAY, sdtc_pkg::BASE_SECOND, 1'b1, 1'b0, 1'b0, 1'b0, 13'h1FFE);
    check({err, done}, 16'h0001);
    run(sdtc_pkg::OP_ON_DELAY, sdtc_pkg::BASE_SECOND, 1'b1, 1'b0, 1'b0, 1'b0, 13'h1FFF);
    check({err, done}, 16'h0002);
  endtask

  //////////////////////////////////////////////////////////////////////////////
  initial
  begin
    clk_sys_i = 1'b0;
    forever #4 clk_sys_i = ~clk_sys_i;
  end

  initial
  begin
    {arst_n_i, pwr, exec, rung, sgn, fen, fval, dm_we} = '0;
    op = sdtc_pkg::OP_ON_DELAY;
    base = sdtc_pkg::BASE_SECOND;
    paddr = PAIR_A;
    dm_addr = PAIR_A;
    dm_wdata = 16'h0000;
    err_count = 0;
    samples_checked = 0;
    repeat (20) @(posedge clk_sys_i);
    #1;
    arst_n_i = 1'b1;
    on_delay(sdtc_pkg::BASE_HUNDREDTH, 16'h0007, 3, 1'b1);
    on_delay(sdtc_pkg::BASE_TENTH, 16'h0002, 30, 1'b1);
    on_delay(sdtc_pkg::BASE_SECOND, 16'h0002, 30, 1'b0);
    power_return;
    counting;
    force_and_refuse;
    report_and_stop;
  end
endmodule
